//--- design/supervisor_trap_pkg.sv
// Constants, field layouts and carrier types of the supervisor trap unit.
// Assumes a 32-bit hart and a CSR port indexed by the CSR_* indices below.
package supervisor_trap_pkg;
    localparam int XLEN = 32;
    localparam int CODE_W = 4;

    // CSR port indices
    localparam logic [2:0] CSR_STATUS  = 3'h0;
    localparam logic [2:0] CSR_IRQ_EN  = 3'h1;
    localparam logic [2:0] CSR_TVEC    = 3'h2;
    localparam logic [2:0] CSR_SCRATCH = 3'h3;
    localparam logic [2:0] CSR_EPC     = 3'h4;
    localparam logic [2:0] CSR_CAUSE   = 3'h5;
    localparam logic [2:0] CSR_BADADDR = 3'h6;
    localparam logic [2:0] CSR_IRQ_PND = 3'h7;

    // Interrupt pending and enable bit positions
    localparam int BIT_USW = 0;
    localparam int BIT_SSW = 1;
    localparam int BIT_UTM = 4;
    localparam int BIT_STM = 5;
    localparam int BIT_UEX = 8;
    localparam int BIT_SEX = 9;
    localparam logic [31:0] IRQ_ALL_MASK = 32'h0000_0333;
    localparam logic [31:0] IRQ_SUP_MASK = 32'h0000_0222;

    // Status subset bit positions
    localparam int ST_UIE  = 0;
    localparam int ST_SIE  = 1;
    localparam int ST_UPIE = 4;
    localparam int ST_SUP_PREV_IRQ_EN = 5;
    localparam int ST_SPP  = 8;
    localparam int ST_PUM  = 18;

    localparam int CAUSE_IRQ_BIT = XLEN - 1;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Interrupt cause codes
    localparam logic [3:0] IRQ_USW = 4'h0;
    localparam logic [3:0] IRQ_SSW = 4'h1;
    localparam logic [3:0] IRQ_UTM = 4'h4;
    localparam logic [3:0] IRQ_STM = 4'h5;
    localparam logic [3:0] IRQ_UEX = 4'h8;
    localparam logic [3:0] IRQ_SEX = 4'h9;
    // Exception cause codes
    localparam logic [3:0] EXC_FETCH_MISALIGN = 4'h0;
    localparam logic [3:0] EXC_FETCH_FAULT    = 4'h1;
    localparam logic [3:0] EXC_ILLEGAL        = 4'h2;
    localparam logic [3:0] EXC_BREAKPOINT     = 4'h3;
    localparam logic [3:0] EXC_LOAD_FAULT     = 4'h5;
    localparam logic [3:0] EXC_AMO_MISALIGN   = 4'h6;
    localparam logic [3:0] EXC_STORE_FAULT    = 4'h7;
    localparam logic [3:0] EXC_ECALL          = 4'h8;

    typedef struct packed {
        logic              valid;
        logic              is_irq;
        logic [CODE_W-1:0] code;
        logic [XLEN-1:0]   pc;
        logic [XLEN-1:0]   badaddr;
    } trap_req_t;

    typedef struct packed {
        logic            we;
        logic            re;
        logic [2:0]      addr;
        logic [XLEN-1:0] wdata;
    } csr_req_t;
endpackage : supervisor_trap_pkg

//--- design/supervisor_trap_csr_unit.sv
// Supervisor trap and interrupt CSR state for one hart, with its vectoring,
// interrupt arbitration and user-page protection check.
// Assumes the pipeline presents one trap at a time and holds the hart's mode.
`timescale 1ns/100ps

module supervisor_trap_csr_unit #(
    parameter bit USER_IRQ   = 1'b1,
    parameter bit HALF_ALIGN = 1'b1
) (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst,
    input  wire supervisor_trap_pkg::csr_req_t    i_csr,
    output logic [supervisor_trap_pkg::XLEN-1:0]  o_csr_rdata,
    output logic                                  o_csr_rvalid,
    input  wire logic                             i_priv_sup,
    input  wire supervisor_trap_pkg::trap_req_t   i_trap,
    output logic                                  o_redirect_valid,
    output logic [supervisor_trap_pkg::XLEN-1:0]  o_redirect_pc,
    input  wire logic                             i_sw_irq_set,
    input  wire logic                             i_sup_timer_irq,
    input  wire logic                             i_sup_ext_irq,
    input  wire logic                             i_user_timer_irq,
    input  wire logic                             i_user_ext_irq,
    output logic                                  o_irq_req,
    output logic [supervisor_trap_pkg::CODE_W-1:0] o_irq_code,
    input  wire logic                             i_mem_valid,
    input  wire logic                             i_mem_user_page,
    output logic                                  o_mem_fault
);
    localparam logic [31:0] IMPL_MASK = USER_IRQ ? supervisor_trap_pkg::IRQ_ALL_MASK
                                                 : supervisor_trap_pkg::IRQ_SUP_MASK;
    localparam logic [31:0] EPC_MASK  = HALF_ALIGN ? 32'hFFFF_FFFE : 32'hFFFF_FFFC;
    localparam logic [31:0] TVEC_MASK = 32'hFFFF_FFFC;

    logic [31:0] irq_en_q;
    logic [1:0]  sw_pend_q;
    logic [3:0]  hw_pend_q;
    logic        sie_q, uie_q, sup_prev_irq_en_q, upie_q, spp_q, pum_q;
    logic [31:0] tvec_q, scratch_q, epc_q, badaddr_q;
    logic        cause_irq_q;
    logic [3:0]  cause_code_q;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic        redir_q;
    logic [31:0] redir_pc_q;
    logic        irq_req_q;
    logic [3:0]  irq_code_q;
    logic        mem_fault_q;

    logic [31:0] pend_vec;
    logic [31:0] active;
    logic        glob_sup;
    logic        glob_user;
    logic        irq_any_d;
    logic [3:0]  irq_code_d;
    logic        wr_status, wr_en, wr_tvec, wr_scratch;
    logic        wr_epc, wr_cause, wr_badaddr, wr_pend;
    logic        addr_trap;

    assign wr_status  = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_STATUS;
    assign wr_en      = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_IRQ_EN;
    assign wr_tvec    = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_TVEC;
    assign wr_scratch = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_SCRATCH;
    assign wr_epc     = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_EPC;
    assign wr_cause   = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_CAUSE;
    assign wr_badaddr = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_BADADDR;
    assign wr_pend    = i_csr.we && i_csr.addr == supervisor_trap_pkg::CSR_IRQ_PND;

    // Only supported codes survive a software write
    function automatic logic code_legal(input logic irq, input logic [3:0] code);
        if (irq) begin
            code_legal = code == supervisor_trap_pkg::IRQ_USW || code == supervisor_trap_pkg::IRQ_SSW ||
                         code == supervisor_trap_pkg::IRQ_UTM || code == supervisor_trap_pkg::IRQ_STM ||
                         code == supervisor_trap_pkg::IRQ_UEX || code == supervisor_trap_pkg::IRQ_SEX;
        end else begin
            code_legal = code <= supervisor_trap_pkg::EXC_ECALL &&
                         code != 4'h4;
        end
    endfunction : code_legal

    // Which exceptions carry a faulting address
    assign addr_trap = !i_trap.is_irq &&
                       (i_trap.code == supervisor_trap_pkg::EXC_FETCH_MISALIGN ||
                        i_trap.code == supervisor_trap_pkg::EXC_FETCH_FAULT ||
                        i_trap.code == supervisor_trap_pkg::EXC_BREAKPOINT ||
                        i_trap.code == supervisor_trap_pkg::EXC_LOAD_FAULT ||
                        i_trap.code == supervisor_trap_pkg::EXC_AMO_MISALIGN ||
                        i_trap.code == supervisor_trap_pkg::EXC_STORE_FAULT);

    // Pending view; hardwired bits fall away through the implementation mask
    always_comb begin
        pend_vec = supervisor_trap_pkg::RST_WORD;
        pend_vec[supervisor_trap_pkg::BIT_USW] = sw_pend_q[0];
        pend_vec[supervisor_trap_pkg::BIT_SSW] = sw_pend_q[1];
        pend_vec[supervisor_trap_pkg::BIT_UTM] = hw_pend_q[0];
        pend_vec[supervisor_trap_pkg::BIT_STM] = hw_pend_q[1];
        pend_vec[supervisor_trap_pkg::BIT_UEX] = hw_pend_q[2];
        pend_vec[supervisor_trap_pkg::BIT_SEX] = hw_pend_q[3];
        pend_vec = pend_vec & IMPL_MASK;
    end

    assign active    = pend_vec & irq_en_q;
    assign glob_sup  = !i_priv_sup || sie_q;
    assign glob_user = !i_priv_sup && uie_q;

    // Supervisor sources first, then user; external over software over timer
    always_comb begin
        irq_any_d  = 1'b0;
        irq_code_d = supervisor_trap_pkg::IRQ_USW;
        if (glob_sup && active[supervisor_trap_pkg::BIT_SEX]) begin
            irq_any_d  = 1'b1;
            irq_code_d = supervisor_trap_pkg::IRQ_SEX;
        end else if (glob_sup && active[supervisor_trap_pkg::BIT_SSW]) begin
            irq_any_d  = 1'b1;
            irq_code_d = supervisor_trap_pkg::IRQ_SSW;
        end else if (glob_sup && active[supervisor_trap_pkg::BIT_STM]) begin
            irq_any_d  = 1'b1;
            irq_code_d = supervisor_trap_pkg::IRQ_STM;
        end else if (glob_user && active[supervisor_trap_pkg::BIT_UEX]) begin
            irq_any_d  = 1'b1;
            irq_code_d = supervisor_trap_pkg::IRQ_UEX;
        end else if (glob_user && active[supervisor_trap_pkg::BIT_USW]) begin
            irq_any_d  = 1'b1;
            irq_code_d = supervisor_trap_pkg::IRQ_USW;
        end else if (glob_user && active[supervisor_trap_pkg::BIT_UTM]) begin
            irq_any_d  = 1'b1;
            irq_code_d = supervisor_trap_pkg::IRQ_UTM;
        end
    end

    // Enable bits are the machine-level storage itself
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_en_q <= supervisor_trap_pkg::RST_WORD;
        end else if (wr_en) begin
            irq_en_q <= i_csr.wdata & IMPL_MASK;
        end
    end

    // Software pending bits; a remote set wins over a local clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sw_pend_q <= 2'h0;
        end else begin
            if (wr_pend) begin
                sw_pend_q[1] <= i_csr.wdata[supervisor_trap_pkg::BIT_SSW] || i_sw_irq_set;
                sw_pend_q[0] <= i_csr.wdata[supervisor_trap_pkg::BIT_USW] && USER_IRQ;
            end else if (i_sw_irq_set) begin
                sw_pend_q[1] <= 1'b1;
            end
        end
    end

    // Hardware pending bits mirror their sources and ignore writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hw_pend_q <= 4'h0;
        end else begin
            hw_pend_q <= {i_sup_ext_irq, i_user_ext_irq, i_sup_timer_irq, i_user_timer_irq};
        end
    end

    // Status subset; a trap overrides a same-cycle software write
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sie_q  <= 1'b0;
            uie_q  <= 1'b0;
            sup_prev_irq_en_q <= 1'b0;
            upie_q <= 1'b0;
            spp_q  <= 1'b0;
            pum_q  <= 1'b0;
        end else if (i_trap.valid) begin
            sup_prev_irq_en_q <= i_priv_sup ? sie_q : uie_q;
            sie_q  <= 1'b0;
            spp_q  <= i_priv_sup;
        end else if (wr_status) begin
            sie_q  <= i_csr.wdata[supervisor_trap_pkg::ST_SIE];
            uie_q  <= i_csr.wdata[supervisor_trap_pkg::ST_UIE] && USER_IRQ;
            sup_prev_irq_en_q <= i_csr.wdata[supervisor_trap_pkg::ST_SUP_PREV_IRQ_EN];
            upie_q <= i_csr.wdata[supervisor_trap_pkg::ST_UPIE] && USER_IRQ;
            spp_q  <= i_csr.wdata[supervisor_trap_pkg::ST_SPP];
            pum_q  <= i_csr.wdata[supervisor_trap_pkg::ST_PUM];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tvec_q <= supervisor_trap_pkg::RST_WORD;
        end else if (wr_tvec) begin
            tvec_q <= i_csr.wdata & TVEC_MASK;
        end
    end

    // No hardware reads the scratch word
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scratch_q <= supervisor_trap_pkg::RST_WORD;
        end else if (wr_scratch) begin
            scratch_q <= i_csr.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            epc_q <= supervisor_trap_pkg::RST_WORD;
        end else if (i_trap.valid) begin
            epc_q <= i_trap.pc & EPC_MASK;
        end else if (wr_epc) begin
            epc_q <= i_csr.wdata & EPC_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cause_irq_q  <= 1'b0;
            cause_code_q <= 4'h0;
        end else if (i_trap.valid) begin
            cause_irq_q  <= i_trap.is_irq;
            cause_code_q <= i_trap.code;
        end else if (wr_cause) begin
            cause_irq_q <= i_csr.wdata[supervisor_trap_pkg::CAUSE_IRQ_BIT];
            // Illegal codes are replaced by the code held before
            if (code_legal(i_csr.wdata[supervisor_trap_pkg::CAUSE_IRQ_BIT], i_csr.wdata[3:0])) begin
                cause_code_q <= i_csr.wdata[3:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            badaddr_q <= supervisor_trap_pkg::RST_WORD;
        end else if (i_trap.valid) begin
            if (addr_trap) begin
                badaddr_q <= i_trap.badaddr;
            end
        end else if (wr_badaddr) begin
            badaddr_q <= i_csr.wdata;
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q  <= supervisor_trap_pkg::RST_WORD;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_csr.re;
            if (i_csr.re) begin
                unique case (i_csr.addr)
                    supervisor_trap_pkg::CSR_STATUS: begin
                        rdata_q <= (32'(sie_q) << supervisor_trap_pkg::ST_SIE) |
                                   (32'(uie_q) << supervisor_trap_pkg::ST_UIE) |
                                   (32'(sup_prev_irq_en_q) << supervisor_trap_pkg::ST_SUP_PREV_IRQ_EN) |
                                   (32'(upie_q) << supervisor_trap_pkg::ST_UPIE) |
                                   (32'(spp_q) << supervisor_trap_pkg::ST_SPP) |
                                   (32'(pum_q) << supervisor_trap_pkg::ST_PUM);
                    end
                    supervisor_trap_pkg::CSR_IRQ_EN:  rdata_q <= irq_en_q;
                    supervisor_trap_pkg::CSR_TVEC:    rdata_q <= tvec_q;
                    supervisor_trap_pkg::CSR_SCRATCH: rdata_q <= scratch_q;
                    supervisor_trap_pkg::CSR_EPC:     rdata_q <= epc_q;
                    supervisor_trap_pkg::CSR_CAUSE:   rdata_q <= {cause_irq_q, 27'h0, cause_code_q};
                    supervisor_trap_pkg::CSR_BADADDR: rdata_q <= badaddr_q;
                    supervisor_trap_pkg::CSR_IRQ_PND: rdata_q <= pend_vec;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            redir_q    <= 1'b0;
            redir_pc_q <= supervisor_trap_pkg::RST_WORD;
        end else begin
            redir_q    <= i_trap.valid;
            redir_pc_q <= tvec_q;
        end
    end

    // Request stays low for the cycle after a trap so the handler starts masked
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_req_q  <= 1'b0;
            irq_code_q <= 4'h0;
        end else begin
            irq_req_q  <= irq_any_d && !i_trap.valid;
            irq_code_q <= irq_code_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mem_fault_q <= 1'b0;
        end else begin
            mem_fault_q <= i_mem_valid && i_priv_sup && pum_q && i_mem_user_page;
        end
    end

    assign o_csr_rdata      = rdata_q;
    assign o_csr_rvalid     = rvalid_q;
    assign o_redirect_valid = redir_q;
    assign o_redirect_pc    = redir_pc_q;
    assign o_irq_req        = irq_req_q;
    assign o_irq_code       = irq_code_q;
    assign o_mem_fault      = mem_fault_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_pum_fault;
        (i_mem_valid && i_mem_user_page) |=> (o_mem_fault == $past(i_priv_sup && pum_q));
    endproperty
    a_pum_fault: assert property (p_pum_fault) else $error("user page fault wrong");

    property p_vector;
        i_trap.valid |=> o_redirect_valid && o_redirect_pc == $past(tvec_q);
    endproperty
    a_vector: assert property (p_vector) else $error("trap vector wrong");

    property p_tvec_write;
        wr_tvec |=> tvec_q == {$past(i_csr.wdata[31:2]), 2'b00};
    endproperty
    a_tvec_write: assert property (p_tvec_write) else $error("vector base not aligned");

    property p_en_layout;
        wr_en |=> irq_en_q == ($past(i_csr.wdata) & IMPL_MASK);
    endproperty
    a_en_layout: assert property (p_en_layout) else $error("enable layout wrong");

    property p_ssw_write;
        (wr_pend && !i_sw_irq_set) |=> sw_pend_q[1] == $past(i_csr.wdata[supervisor_trap_pkg::BIT_SSW]);
    endproperty
    a_ssw_write: assert property (p_ssw_write) else $error("software pending write lost");

    property p_ssw_gate;
        (o_irq_req && o_irq_code == supervisor_trap_pkg::IRQ_SSW) |-> $past(irq_en_q[supervisor_trap_pkg::BIT_SSW]);
    endproperty
    a_ssw_gate: assert property (p_ssw_gate) else $error("disabled software irq taken");

    property p_sie_block;
        (i_priv_sup && !sie_q) |=> !o_irq_req;
    endproperty
    a_sie_block: assert property (p_sie_block) else $error("irq taken with global enable clear");

    property p_prev_en;
        i_trap.valid |=> !sie_q && sup_prev_irq_en_q == $past(i_priv_sup ? sie_q : uie_q);
    endproperty
    a_prev_en: assert property (p_prev_en) else $error("previous enable not saved");

    property p_epc;
        i_trap.valid |=> epc_q == ($past(i_trap.pc) & EPC_MASK) && !epc_q[0];
    endproperty
    a_epc: assert property (p_epc) else $error("return pc wrong");

    property p_cause;
        i_trap.valid |=> cause_irq_q == $past(i_trap.is_irq) && cause_code_q == $past(i_trap.code);
    endproperty
    a_cause: assert property (p_cause) else $error("cause wrong");

    property p_badaddr_keep;
        (i_trap.valid && !addr_trap) |=> $stable(badaddr_q);
    endproperty
    a_badaddr_keep: assert property (p_badaddr_keep) else $error("fault address changed");

    property p_hw_pend;
        ##1 hw_pend_q[3] == $past(i_sup_ext_irq);
    endproperty
    a_hw_pend: assert property (p_hw_pend) else $error("external pending wrong");

    c_irq_trap: cover property (i_trap.valid && i_trap.is_irq);
    c_addr_trap: cover property (i_trap.valid && addr_trap ##1 redir_q);
    c_pum: cover property (o_mem_fault);
    c_irq_req: cover property (o_irq_req && o_irq_code == supervisor_trap_pkg::IRQ_SEX);
endmodule : supervisor_trap_csr_unit

//--- bench/irq_source_model.sv
// Machine-level interrupt sources that feed the trap unit's pending bits.
// Assumes the bench requests levels just after a clock edge.
`timescale 1ns/100ps
module irq_source_model (
    input  wire logic       i_clk,
    input  wire logic [4:0] i_want,
    output logic            o_sw_set,
    output logic            o_sup_timer,
    output logic            o_sup_ext,
    output logic            o_user_timer,
    output logic            o_user_ext
);
    // Registered so the levels move only after an edge, like the real source logic
    always_ff @(posedge i_clk) begin
        {o_user_ext, o_user_timer, o_sup_ext, o_sup_timer} <= i_want[3:0];
        o_sw_set <= i_want[4];
    end
endmodule : irq_source_model

//--- bench/tb_top.sv
// Self-checking bench for the supervisor trap unit.
// Assumes the fixed one-edge answers of the CSR, trap and protect ports.
`timescale 1ns/100ps
module tb_top;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    supervisor_trap_pkg::csr_req_t  csr = '0;
    supervisor_trap_pkg::trap_req_t trap = '0;
    logic                           psup = 1'b0;
    logic                           mv = 1'b0;
    logic                           upg = 1'b1;
    logic [31:0]                    rdata_lite;
    logic [4:0]                     want = 5'h00;
    logic [31:0]                    rdata;
    logic [31:0]                    rpc;
    logic [3:0]                     icode;
    logic                           rvalid, rdv, irq, mfault, sws, stm, sex, utm, uex;
    int                             fails = 0;
    int                             compares = 0;

    always #2 clk = ~clk;

    irq_source_model u_src (.i_clk(clk), .i_want(want), .o_sw_set(sws), .o_sup_timer(stm),
        .o_sup_ext(sex), .o_user_timer(utm), .o_user_ext(uex));

    supervisor_trap_csr_unit u_dut (.i_clk(clk), .i_rst(rst), .i_csr(csr), .o_csr_rdata(rdata),
        .o_csr_rvalid(rvalid), .i_priv_sup(psup), .i_trap(trap), .o_redirect_valid(rdv),
        .o_redirect_pc(rpc), .i_sw_irq_set(sws), .i_sup_timer_irq(stm), .i_sup_ext_irq(sex),
        .i_user_timer_irq(utm), .i_user_ext_irq(uex), .o_irq_req(irq), .o_irq_code(icode),
        .i_mem_valid(mv), .i_mem_user_page(upg), .o_mem_fault(mfault));

    // Second copy without user interrupts and without 16-bit alignment
    supervisor_trap_csr_unit #(.USER_IRQ(1'b0), .HALF_ALIGN(1'b0)) u_dut_lite (.i_clk(clk), .i_rst(rst),
        .i_csr(csr), .o_csr_rdata(rdata_lite), .o_csr_rvalid(), .i_priv_sup(psup), .i_trap(trap),
        .o_redirect_valid(), .o_redirect_pc(), .i_sw_irq_set(sws), .i_sup_timer_irq(stm),
        .i_sup_ext_irq(sex), .i_user_timer_irq(utm), .i_user_ext_irq(uex), .o_irq_req(), .o_irq_code(),
        .i_mem_valid(mv), .i_mem_user_page(upg), .o_mem_fault());

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        csr = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk) #1;
        csr = '0;
        @(posedge clk) #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [31:0] exp);
        csr = '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk) #1;
        csr = '0;
        chk({31'h0, rvalid}, 32'h1);
        chk(rdata, exp);
        @(posedge clk) #1;
    endtask : rd

    task automatic take(input logic f, input logic [3:0] c, input logic [31:0] pc, input logic [31:0] ba);
        trap = '{valid: 1'b1, is_irq: f, code: c, pc: pc, badaddr: ba};
        @(posedge clk) #1;
        trap = '0;
        chk({31'h0, rdv}, 32'h1);
        chk(rpc, 32'h1234_5674);
        @(posedge clk) #1;
    endtask : take

    // Pending levels take three register stages to the request, so three edges always suffice
    task automatic irq_chk(input logic r, input logic [3:0] c);
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, r});
        if (r) chk({28'h0, icode}, {28'h0, c});
    endtask : irq_chk

    task automatic mem(input logic s, input logic u, input logic exp);
        psup = s;
        upg = u;
        mv = 1'b1;
        @(posedge clk) #1;
        mv = 1'b0;
        chk({31'h0, mfault}, {31'h0, exp});
        @(posedge clk) #1;
    endtask : mem

    task automatic final_report;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        wr(supervisor_trap_pkg::CSR_TVEC, 32'h1234_5677);
        rd(supervisor_trap_pkg::CSR_TVEC, 32'h1234_5674);
        wr(supervisor_trap_pkg::CSR_IRQ_EN, 32'hFFFF_FFFF);
        rd(supervisor_trap_pkg::CSR_IRQ_EN, 32'h0000_0333);
        chk(rdata_lite, 32'h0000_0222);
        wr(supervisor_trap_pkg::CSR_IRQ_PND, 32'hFFFF_FFFF);
        rd(supervisor_trap_pkg::CSR_IRQ_PND, 32'h0000_0003);
        chk(rdata_lite, 32'h0000_0002);
        wr(supervisor_trap_pkg::CSR_SCRATCH, 32'hA5C3_0F69);
        rd(supervisor_trap_pkg::CSR_SCRATCH, 32'hA5C3_0F69);
        wr(supervisor_trap_pkg::CSR_EPC, 32'hFFFF_FFFF);
        rd(supervisor_trap_pkg::CSR_EPC, 32'hFFFF_FFFE);
        chk(rdata_lite, 32'hFFFF_FFFC);
        irq_chk(1'b1, supervisor_trap_pkg::IRQ_SSW);
        want = 5'h0F;
        irq_chk(1'b1, supervisor_trap_pkg::IRQ_SEX);
        rd(supervisor_trap_pkg::CSR_IRQ_PND, 32'h0000_0333);
        chk(rdata_lite, 32'h0000_0222);
        want = 5'h01;
        wr(supervisor_trap_pkg::CSR_IRQ_PND, 32'h0000_0000);
        irq_chk(1'b1, supervisor_trap_pkg::IRQ_STM);
        wr(supervisor_trap_pkg::CSR_IRQ_EN, 32'h0000_0000);
        irq_chk(1'b0, 4'h0);
        want = 5'h10;
        wr(supervisor_trap_pkg::CSR_IRQ_EN, 32'h0000_0002);
        want = 5'h00;
        irq_chk(1'b1, supervisor_trap_pkg::IRQ_SSW);
        wr(supervisor_trap_pkg::CSR_IRQ_PND, 32'h0000_0001);
        wr(supervisor_trap_pkg::CSR_STATUS, 32'h0000_0001);
        wr(supervisor_trap_pkg::CSR_IRQ_EN, 32'h0000_0333);
        irq_chk(1'b1, supervisor_trap_pkg::IRQ_USW);
        wr(supervisor_trap_pkg::CSR_IRQ_EN, 32'h0000_0332);
        irq_chk(1'b0, 4'h0);
        wr(supervisor_trap_pkg::CSR_IRQ_PND, 32'h0000_0002);
        wr(supervisor_trap_pkg::CSR_STATUS, 32'h0004_0000);
        mem(1'b0, 1'b1, 1'b0);
        mem(1'b1, 1'b1, 1'b1);
        mem(1'b1, 1'b0, 1'b0);
        irq_chk(1'b0, 4'h0);
        wr(supervisor_trap_pkg::CSR_STATUS, 32'h0000_0002);
        irq_chk(1'b1, supervisor_trap_pkg::IRQ_SSW);
        take(1'b0, supervisor_trap_pkg::EXC_FETCH_FAULT, 32'h0000_1000, 32'h0000_1002);
        rd(supervisor_trap_pkg::CSR_EPC, 32'h0000_1000);
        rd(supervisor_trap_pkg::CSR_BADADDR, 32'h0000_1002);
        rd(supervisor_trap_pkg::CSR_CAUSE, 32'h0000_0001);
        rd(supervisor_trap_pkg::CSR_STATUS, 32'h0000_0120);
        take(1'b0, supervisor_trap_pkg::EXC_ILLEGAL, 32'h0000_2000, 32'hDEAD_BEEF);
        rd(supervisor_trap_pkg::CSR_BADADDR, 32'h0000_1002);
        rd(supervisor_trap_pkg::CSR_CAUSE, 32'h0000_0002);
        take(1'b1, supervisor_trap_pkg::IRQ_STM, 32'h0000_3000, 32'h0000_0000);
        rd(supervisor_trap_pkg::CSR_CAUSE, 32'h8000_0005);
        wr(supervisor_trap_pkg::CSR_CAUSE, 32'h0000_000A);
        rd(supervisor_trap_pkg::CSR_CAUSE, 32'h0000_0005);
        final_report();
    end
endmodule : tb_top
